//--- src/ctx_entry_map.vh
// Field layout, codes and register offsets of the context-entry decoder
// Assumes inclusion by the decoder files and the bench
// What this block does
// - Width codes 1,2,3 mean 39,48,57 bits
// - Width sizes walk for types 00,01; respWidth also gives it for type 10
// - Block and fault untranslated address above width limit
// - Table base bits 63:12, masked at host width
// - Table base ignored in pass-through
// - Type 00 translates untranslated, blocks others
// - Type 01 accepts all three request kinds
// - Type 01 reserved without device cache support
// - Type 10 passes untranslated, reserved without support
// - Type applies without identifier; 11 reserved
// - Fault report disable bit suppresses reporting
// - Disable bit honoured even when absent
// - Absent entry faults; only the disable bit and type 10 respWidth still apply
`ifndef CTX_ENTRY_MAP_VH
`define CTX_ENTRY_MAP_VH
`define BIT_PRESENT      0
`define BIT_FRD          1
`define TT_LO            2
`define TT_HI            3
`define RSV_LO           4
`define RSV_HI           11
`define BASE_LO          12
`define BASE_HI          63
`define WIDTH_LO         64
`define WIDTH_HI         66
`define TT_SLP           2'h0
`define TT_ALL           2'h1
`define TT_PASS          2'h2
`define TT_RSV           2'h3
`define WIDTH_39         3'h1
`define WIDTH_48         3'h2
`define WIDTH_57         3'h3
`define KIND_UNTR        2'h0
`define KIND_TRANSLATED  2'h1
`define KIND_XLATE_REQ   2'h2
`define REG_ENTRY_LO     12'h000
`define REG_ENTRY_MID    12'h004
`define REG_ENTRY_HI     12'h008
`define REG_CTRL         12'h00C
`define REG_STATUS       12'h010
`define REG_MASK         12'h014
`define REG_RESULT       12'h018
`define REG_BASE_LO      12'h01C
`define REG_BASE_HI      12'h020
`define CTRL_RESET       32'h0000_0034
`define CTRL_HAW_LO      0
`define CTRL_HAW_HI      5
`define CTRL_DEVCACHE    6
`define CTRL_PASS        7
`define EV_DONE          0
`define EV_FAULT         1
`define EV_BLOCK         2
`endif

//--- src/width_check.v
// Decodes the width code and checks an address against its limit
// Assumes a same-clock caller; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ctx_entry_map.vh"
module width_check (
  input  wire [2:0]  widthCode,
  input  wire [63:0] addr,
  output reg  [5:0]  widthBits,
  output reg         codeValid,
  output wire        outOfRange
);
  always @* begin
    codeValid = 1'b1;
    case (widthCode)
      `WIDTH_39: widthBits = 6'h27;
      `WIDTH_48: widthBits = 6'h30;
      `WIDTH_57: widthBits = 6'h39;
      default: begin
        widthBits = 6'h00;
        codeValid = 1'b0;
      end
    endcase
  end
  // Any set bit at or above the width exceeds 2^width - 1
  assign outOfRange = codeValid && ((addr >> widthBits) != 64'h0);
endmodule
`default_nettype wire

//--- src/context_entry_decode.v
// Context-entry low-half decoder with APB registers and request check
// Assumes an APB master on mclk and requests from logic on mclk
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ctx_entry_map.vh"
module context_entry_decode (
  input  wire        mclk,
  input  wire        reset,
  input  wire        clkEn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        reqValid,
  input  wire [1:0]  reqKind,
  input  wire        reqHasPasid,
  input  wire [63:0] reqAddr,
  output wire        reqReady,
  output reg         respValid,
  output reg         respAllow,
  output reg         respPass,
  output reg         respFault,
  output reg         respReport,
  output reg  [63:0] respTableBase,
  output reg  [5:0]  respWidth,
  output wire        irq
);
  reg  [31:0] entryLo;
  reg  [31:0] entryMid;
  reg  [2:0]  entryHi;
  reg  [31:0] ctrl;
  reg  [2:0]  status;
  reg  [2:0]  mask;
  reg  [2:0]  next_status;
  reg         setAllow;
  reg         setPass;
  reg         setFault;
  wire [63:0] hostMask;
  wire [63:0] entry;
  wire        present;
  wire        frd;
  wire [1:0]  ttype;
  wire [5:0]  widthBits;
  wire        codeValid;
  wire        outOfRange;
  wire        ttReserved;
  wire        useWidth;
  wire        wr;
  wire        rd;
  wire [5:0]  host_addr_bits;
  wire [2:0]  events;
  genvar      g;

  function isAddr;
    input [11:0] a;
    input [11:0] target;
    begin
      isAddr = (a == target);
    end
  endfunction

  assign entry   = {entryMid, entryLo};
  assign present = entry[`BIT_PRESENT];
  assign frd     = entry[`BIT_FRD];
  assign ttype   = entry[`TT_HI:`TT_LO];
  assign host_addr_bits     = ctrl[`CTRL_HAW_HI:`CTRL_HAW_LO];
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = clkEn && psel && penable && pwrite;
  assign rd      = clkEn && psel && penable && !pwrite;
  assign reqReady = 1'b1;

  width_check widthDecode (
    .widthCode  (entryHi),
    .addr       (reqAddr),
    .widthBits  (widthBits),
    .codeValid  (codeValid),
    .outOfRange (outOfRange)
  );

  // Reserved type codes depend on reported capabilities
  assign ttReserved = (ttype == `TT_RSV)
                   || (ttype == `TT_ALL && !ctrl[`CTRL_DEVCACHE])
                   || (ttype == `TT_PASS && !ctrl[`CTRL_PASS]);
  assign useWidth = (ttype == `TT_SLP) || (ttype == `TT_ALL);

  // Keeps only table base bits below the host address width
  generate
    for (g = 0; g < 64; g = g + 1) begin : hostMaskBits
      assign hostMask[g] = (g < host_addr_bits);
    end
  endgenerate

  // Request decision
  always @* begin
    setAllow = 1'b0;
    setPass  = 1'b0;
    setFault = 1'b0;
    if (!present) begin
      setFault = 1'b1;
    end else if (reqHasPasid) begin
      setFault = 1'b0;
    end else if (ttReserved || (useWidth && !codeValid)) begin
      setFault = 1'b1;
    end else begin
      case (ttype)
        `TT_SLP: begin
          if (reqKind == `KIND_UNTR) begin
            setAllow = !outOfRange;
            setFault = outOfRange;
          end else begin
            setFault = 1'b1;
          end
        end
        `TT_ALL: begin
          if (reqKind == `KIND_UNTR) begin
            setAllow = !outOfRange;
            setFault = outOfRange;
          end else begin
            setAllow = 1'b1;
          end
        end
        `TT_PASS: begin
          if (reqKind == `KIND_UNTR) begin
            setAllow = !outOfRange;
            setPass  = !outOfRange;
            setFault = outOfRange;
          end else begin
            setFault = 1'b1;
          end
        end
        default: setFault = 1'b1;
      endcase
    end
  end

  assign events = {respValid && !respAllow, respValid && respReport, respValid};

  always @* begin
    next_status = status;
    if (rd && isAddr(paddr, `REG_STATUS)) begin
      next_status = 3'h0;
    end
    next_status = next_status | events;
  end

  always @(posedge mclk) begin
    if (reset) begin
      entryLo       <= 32'h0;
      entryMid      <= 32'h0;
      entryHi       <= 3'h0;
      ctrl          <= `CTRL_RESET;
      status        <= 3'h0;
      mask          <= 3'h0;
      respValid     <= 1'b0;
      respAllow     <= 1'b0;
      respPass      <= 1'b0;
      respFault     <= 1'b0;
      respReport    <= 1'b0;
      respTableBase <= 64'h0;
      respWidth     <= 6'h00;
    end else if (clkEn) begin
      status <= next_status;
      if (wr) begin
        if (isAddr(paddr, `REG_ENTRY_LO)) entryLo <= pwdata;
        if (isAddr(paddr, `REG_ENTRY_MID)) entryMid <= pwdata;
        if (isAddr(paddr, `REG_ENTRY_HI)) entryHi <= pwdata[2:0];
        if (isAddr(paddr, `REG_CTRL)) ctrl <= {24'h0, pwdata[7:0]};
        if (isAddr(paddr, `REG_MASK)) mask <= pwdata[2:0];
      end
      respValid  <= reqValid;
      respAllow  <= reqValid && setAllow;
      respPass   <= reqValid && setPass;
      respFault  <= reqValid && setFault;
      respReport <= reqValid && setFault && !frd;
      if (reqValid && present && useWidth && !ttReserved) begin
        respTableBase <= {entry[`BASE_HI:`BASE_LO], 12'h000} & hostMask;
        respWidth     <= widthBits;
      end else begin
        respTableBase <= 64'h0;
        respWidth     <= (ttype == `TT_PASS) ? widthBits : 6'h00;
      end
    end
  end

  always @* begin
    prdata = 32'h0;
    if (isAddr(paddr, `REG_ENTRY_LO)) prdata = entryLo;
    else if (isAddr(paddr, `REG_ENTRY_MID)) prdata = entryMid;
    else if (isAddr(paddr, `REG_ENTRY_HI)) prdata = {29'h0, entryHi};
    else if (isAddr(paddr, `REG_CTRL)) prdata = ctrl;
    else if (isAddr(paddr, `REG_STATUS)) prdata = {29'h0, status};
    else if (isAddr(paddr, `REG_MASK)) prdata = {29'h0, mask};
    else if (isAddr(paddr, `REG_RESULT)) prdata = {26'h0, respWidth};
    else if (isAddr(paddr, `REG_BASE_LO)) prdata = respTableBase[31:0];
    else if (isAddr(paddr, `REG_BASE_HI)) prdata = respTableBase[63:32];
  end

  assign irq = |(status & mask);
endmodule
`default_nettype wire

//--- testbench/dma_source.sv
// Model of an I/O device issuing one request per go pulse
// Assumes go is driven one mclk cycle per request
`timescale 1ns/1ps
`default_nettype none
module dma_source (
  input  wire         mclk,
  input  wire         go,
  input  wire  [1:0]  kind,
  input  wire         pasid,
  input  wire  [63:0] addr,
  output logic        reqValid,
  output logic [1:0]  reqKind,
  output logic        reqHasPasid,
  output logic [63:0] reqAddr
);
  initial {reqValid, reqKind, reqHasPasid, reqAddr} = '0;
  // Idle fields turn over so stale values never look valid
  always @(posedge mclk) begin
    reqValid <= go;
    reqKind <= go ? kind : ~reqKind;
    reqHasPasid <= go ? pasid : ~reqHasPasid;
    reqAddr <= go ? addr : ~reqAddr;
  end
endmodule
`default_nettype wire

//--- testbench/ctx_decode_asserts.sv
// Port assertions for the context-entry decoder
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ctx_decode_chk (
  input wire        mclk,
  input wire        reset,
  input wire        clkEn,
  input wire        reqValid,
  input wire        respValid,
  input wire        respAllow,
  input wire        respPass,
  input wire        respFault,
  input wire        respReport,
  input wire [63:0] respTableBase,
  input wire [5:0]  respWidth
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_resp_follows: assert property (reqValid && clkEn |=> respValid)
    else $error("missing response");
  chk_resp_pulse: assert property (!reqValid && clkEn |=> !respValid)
    else $error("extra response");
  chk_report_gate: assert property (respValid && respReport |-> respFault)
    else $error("report without fault");
  chk_allow_excl: assert property (respValid && respAllow |-> !respFault)
    else $error("allowed and faulted");
  chk_pass_base: assert property (respValid && respPass |-> respTableBase == 64'h0)
    else $error("base in pass-through");
  chk_pass_clean: assert property (respValid && respPass |-> !respFault)
    else $error("pass with fault");
  chk_base_align: assert property (respValid |-> respTableBase[11:0] == 12'h000)
    else $error("base misaligned");
  chk_width_code: assert property (respValid && respWidth != 6'h00 |->
    respWidth == 6'h27 || respWidth == 6'h30 || respWidth == 6'h39)
    else $error("bad width");
endmodule
bind context_entry_decode ctx_decode_chk u_chk (.*);
`default_nettype wire

//--- testbench/tb_top.sv
// Random and corner-case bench for the context-entry decoder
// Assumes the decoder, its header and the request model are compiled
`timescale 1ns/1ps
`default_nettype none
`include "ctx_entry_map.vh"
module tb_top;
  logic        mclk, reset, psel, penable, pwrite, go, pasid, rsv, oor, f, ap, r;
  logic        pready, pslverr, reqValid, reqHasPasid, reqReady, irq, clkEn;
  logic        respValid, respAllow, respPass, respFault, respReport;
  logic [1:0]  kind, reqKind, t;
  logic [5:0]  respWidth, xw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] cfg [4];
  logic [63:0] addr, reqAddr, respTableBase, xb;
  integer      seed = 87937, n_mismatch = 0, n_tests = 0, i, j;
  context_entry_decode DUT (.*);
  dma_source src (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function [5:0] wb(input [2:0] c);
    wb = 6'h1E + 6'h09 * c;
  endfunction
  function [3:0] expv(input [1:0] k, input p, input [63:0] a);
    t = cfg[0][3:2];
    rsv = t == 2'h3 || (t == 2'h1 && !cfg[3][6]) || (t == 2'h2 && !cfg[3][7]);
    oor = (a >> wb(cfg[2][2:0])) != 64'h0;
    ap = 1'b0;
    f = !cfg[0][0] || (!p && rsv);
    if (!f && !p && t == 2'h1) begin
      f = k == 2'h0 && oor;
      ap = !f;
    end else if (!f && !p) begin
      ap = k == 2'h0 && !oor;
      f = !ap;
    end
    xb = (!cfg[0][0] || rsv || t == 2'h2) ? 64'h0 :
      {cfg[1], cfg[0][31:12], 12'h000} & ((64'h1 << cfg[3][5:0]) - 64'h1);
    xw = (cfg[0][0] && !rsv && !t[1]) ? wb(cfg[2][2:0]) : 6'h00;
    expv = {ap, ap && t == 2'h2, f, f && !cfg[0][1]};
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(posedge mclk);
      r = pready === 1'b1;
      rd = prdata;
    end
    {psel, penable} <= 2'h0;
  endtask
  task req(input [1:0] k, input p, input [63:0] a);
    @(posedge mclk);
    {go, kind, pasid, addr} <= {1'b1, k, p, a};
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1 chk({respValid, respAllow | respPass, respPass, respFault, respReport}, {1'b1, expv(k, p, a)});
    if (!p) chk(respTableBase, xb);
    if (!p && xw != 6'h00) chk(respWidth, xw);
  endtask
  task end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000 n_mismatch++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite, go, pasid, kind, paddr, pwdata, addr} = '0;
    clkEn = 1'b1;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1 chk({pready, pslverr, reqReady, respValid, irq}, 5'h14);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 150; i++) begin
      cfg[0] = $random(seed) & 32'hFFFF_F00F;
      cfg[1] = $random(seed);
      cfg[2] = cfg[0][3:2] == 2'h2 ? 32'h3 : 32'h1 + $unsigned($random(seed)) % 3;
      cfg[3] = ($random(seed) & 32'hC0) | (32'h20 + $unsigned($random(seed)) % 21);
      for (j = 0; j < 4; j++) apb(1'b1, 12'(4 * j), cfg[j]);
      for (j = 0; j < 4; j++) begin
        addr = {$random(seed), $random(seed)} >> ($unsigned($random(seed)) % 64);
        if (j < 2) addr = (64'h1 << wb(cfg[2][2:0])) - 64'h1 + j;
        req(2'($unsigned($random(seed)) % 3), ($random(seed) & 7) == 0, addr);
      end
    end
    clkEn <= 1'b0;
    apb(1'b1, `REG_MASK, 32'h7);
    clkEn <= 1'b1;
    apb(1'b0, `REG_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `REG_MASK, 32'h0);
    #1 chk(irq, 1'b0);
    apb(1'b1, `REG_MASK, 32'h7);
    #1 chk(irq, 1'b1);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    #1 chk(irq, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
